// *** iopdd_pkg.sv ***
// package: register map, resets and field layout of the port register block
package iopdd_pkg;
  // register indexes; the byte address of a register is four times its index
  localparam logic [7:0] OFS_PORT_THREE_OUTPUT_DATA = 8'hC6;
  localparam logic [7:0] OFS_PORT_FOUR_OUTPUT_DATA  = 8'hC7;
  localparam logic [7:0] OFS_PORT_FIVE_DIRECTION    = 8'hC8;
  localparam logic [7:0] OFS_PORT_EIGHT_DIRECTION   = 8'hCD;
  localparam logic [7:0] OFS_PORT_SEVEN_PIN_LEVELS  = 8'hCE;
  localparam logic [7:0] OFS_PORT_EIGHT_OUTPUT_DATA = 8'hCF;
  localparam int         ADDR_IDX_LSB               = 2;
  localparam logic [7:0] RST_PORT_DATA              = 8'h00;
  localparam logic [7:0] P5_UNUSED_MASK             = 8'hF0;
  localparam logic [7:0] P8_UNUSED_MASK             = 8'hE0;
  localparam logic [7:0] ALL_ONES                   = 8'hFF;
  localparam int         P5_DIR_BITS                = 4;
  localparam int         P8_DIR_BITS                = 5;
  localparam int         P8_CS_BIT                  = 4;
  localparam logic [2:0] MODE_FIRST_SINGLE_CHIP     = 3'h5;
  localparam logic [1:0] HTRANS_NONSEQ              = 2'h2;
  localparam logic [2:0] HSIZE_WORD                 = 3'h2;
endpackage : iopdd_pkg

// *** iopdd_sync.sv ***
// two-stage synchroniser for a group of pin levels
module iopdd_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : iopdd_sync

// *** iopdd_top.sv ***
// top: port data and direction registers behind an AHB-Lite slave
//
// Overview of operation
// - port three and four data registers, 8-bit read/write, reset zero, drive pins.
// - port eight direction: bits 7-5 read one, 4-0 write-only, bit 4 reset by mode.
// - port eight direction zero is input; one is chip-select or general output.
// - port seven register is read-only and returns the synchronised pin levels.
//
// register reach: each register is one aligned word at four times its index
// only bits 7:0 of a word carry data; upper read bits are zero
// reads take one wait state, writes none; every response is okay
// the mode strap is synchronised, then latched once after reset release
module iopdd_top
  import iopdd_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic [2:0]  i_mode,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic      [7:0]  o_port_three_out,
  output logic      [7:0]  o_port_four_out,
  input  wire logic [7:0]  i_port_seven_pins,
  output logic      [3:0]  o_port_five_dir,
  output logic      [4:0]  o_port_eight_out,
  output logic      [4:0]  o_port_eight_oe_n,
  output logic      [4:0]  o_port_eight_cs_sel
);
  logic [7:0]             port_three_q;
  logic [7:0]             port_four_q;
  logic [P5_DIR_BITS-1:0] port_five_dir_q;
  logic [P8_DIR_BITS-1:0] port_eight_dir_q;
  logic [P8_DIR_BITS-1:0] port_eight_data_q;
  logic [7:0]             port_seven_sync;
  logic                   mode_latched_q;
  logic                   single_chip_q;
  logic                   wr_pend_q;
  logic [7:0]             wr_addr_q;
  logic                   rd_pend_q;
  logic [7:0]             rd_addr_q;
  logic [7:0]             rd_byte;
  logic                   addr_ok;
  logic [3:0]             mode_sync;
  logic                   latch_now;
  logic                   wr_three;
  logic                   wr_four;
  logic                   wr_five;
  logic                   wr_eight_dir;
  logic                   wr_eight_data;

  // pin levels of port seven cross into the clock domain
  iopdd_sync #(.WIDTH(8)) u_p7_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   (i_port_seven_pins),
    .o_sync    (port_seven_sync)
  );

  // mode strap plus a constant one; the one marks when the strap copy is valid
  iopdd_sync #(.WIDTH(4)) u_mode_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   ({1'b1, i_mode}),
    .o_sync    (mode_sync)
  );

  // accepted address phase: selected, ready, non-sequential, whole word
  assign addr_ok = i_hsel & i_hready & (i_htrans == HTRANS_NONSEQ) & (i_hsize == HSIZE_WORD);

  // write strobes of the data phase and the one-shot mode latch
  assign wr_three      = wr_pend_q & (wr_addr_q == OFS_PORT_THREE_OUTPUT_DATA);
  assign wr_four       = wr_pend_q & (wr_addr_q == OFS_PORT_FOUR_OUTPUT_DATA);
  assign wr_five       = wr_pend_q & (wr_addr_q == OFS_PORT_FIVE_DIRECTION);
  assign wr_eight_dir  = wr_pend_q & (wr_addr_q == OFS_PORT_EIGHT_DIRECTION);
  assign wr_eight_data = wr_pend_q & (wr_addr_q == OFS_PORT_EIGHT_OUTPUT_DATA);
  assign latch_now     = ~mode_latched_q & mode_sync[3];

  // catch the synchronised mode strap once after reset release
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_latched_q <= 1'b0;
      single_chip_q  <= 1'b0;
    end else if (latch_now) begin
      mode_latched_q <= 1'b1;
      single_chip_q  <= (mode_sync[2:0] >= MODE_FIRST_SINGLE_CHIP);
    end
  end

  // write address phase capture; the data phase follows in the next cycle
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok & i_hwrite;
      if (addr_ok) wr_addr_q <= i_haddr[ADDR_IDX_LSB +: 8];
    end
  end

  // read address phase capture; data is loaded during the wait state
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= 8'h00;
    end else begin
      rd_pend_q <= addr_ok & ~i_hwrite;
      if (addr_ok) rd_addr_q <= i_haddr[ADDR_IDX_LSB +: 8];
    end
  end

  // port three and four data registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      port_three_q <= RST_PORT_DATA;
      port_four_q  <= RST_PORT_DATA;
    end else begin
      if (wr_three) port_three_q <= i_hwdata[7:0];
      if (wr_four)  port_four_q  <= i_hwdata[7:0];
    end
  end

  // port five direction; writes only take effect in single-chip modes
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      port_five_dir_q <= '0;
    end else if (wr_five && single_chip_q) begin
      port_five_dir_q <= i_hwdata[P5_DIR_BITS-1:0];
    end
  end

  // port eight direction; bit 4 default follows the mode when it is latched
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      port_eight_dir_q <= '0;
    end else if (latch_now) begin
      port_eight_dir_q[P8_CS_BIT] <= (mode_sync[2:0] < MODE_FIRST_SINGLE_CHIP);
    end else if (wr_eight_dir) begin
      port_eight_dir_q <= i_hwdata[P8_DIR_BITS-1:0];
    end
  end

  // port eight data register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      port_eight_data_q <= '0;
    end else if (wr_eight_data) begin
      port_eight_data_q <= i_hwdata[P8_DIR_BITS-1:0];
    end
  end

  // read mux; write-only and unused bits read as one
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_addr_q)
      OFS_PORT_THREE_OUTPUT_DATA: rd_byte = port_three_q;
      OFS_PORT_FOUR_OUTPUT_DATA:  rd_byte = port_four_q;
      OFS_PORT_FIVE_DIRECTION:    rd_byte = ALL_ONES;
      OFS_PORT_EIGHT_DIRECTION:   rd_byte = ALL_ONES;
      OFS_PORT_SEVEN_PIN_LEVELS:  rd_byte = port_seven_sync;
      OFS_PORT_EIGHT_OUTPUT_DATA: rd_byte = P8_UNUSED_MASK | {3'b000, port_eight_data_q};
      default:                    rd_byte = 8'h00;
    endcase
  end

  // one wait state after a read address phase; the response is always okay
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= ~(addr_ok & ~i_hwrite);
      o_hresp     <= 1'b0;
    end
  end

  // read data is loaded in the wait state and held until the next read
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      o_hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // port three and four pins follow their data registers one cycle later
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_port_three_out <= RST_PORT_DATA;
      o_port_four_out  <= RST_PORT_DATA;
    end else begin
      o_port_three_out <= port_three_q;
      o_port_four_out  <= port_four_q;
    end
  end

  // port five pins stay inputs until the mode is known, so no brief drive
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_port_five_dir <= '0;
    end else if (!mode_latched_q) begin
      o_port_five_dir <= '0;
    end else begin
      o_port_five_dir <= single_chip_q ? port_five_dir_q : '1;
    end
  end

  // port eight pins: enable low where the direction bit is set
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_port_eight_out    <= '0;
      o_port_eight_oe_n   <= '1;
      o_port_eight_cs_sel <= '0;
    end else begin
      o_port_eight_out    <= port_eight_data_q;
      o_port_eight_oe_n   <= ~port_eight_dir_q;
      o_port_eight_cs_sel <= single_chip_q ? '0 : port_eight_dir_q;
    end
  end
endmodule : iopdd_top

// *** iopdd_monitor.sv ***
// checker: bus timing and pin relations of the port register block
module iopdd_monitor (
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic [2:0]  i_mode,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic [7:0]  o_port_three_out,
  input wire logic [3:0]  o_port_five_dir,
  input wire logic [4:0]  o_port_eight_oe_n,
  input wire logic [4:0]  o_port_eight_cs_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic [2:0] up_q;
  logic       acc;
  logic       lo;
  // accepted request and expanded-mode class
  assign acc = i_hsel && o_hreadyout && i_htrans == 2'h2;
  assign lo = i_mode < 3'h5;
  // cycles since reset release; the mode settles the pins by the fourth edge
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) up_q <= 3'h0;
    else if (up_q != 3'h4) up_q <= up_q + 3'h1;
  end
  a_pin_three: assert property (acc && i_hwrite && i_haddr[9:2] == 8'hC6
    |-> ##3 o_port_three_out == $past(i_hwdata[7:0], 2)) else $error("port three pins wrong");
  a_read_wait: assert property (acc && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout) else $error("read wait wrong");
  a_wo_ones: assert property (acc && !i_hwrite && i_haddr[9:2] inside {8'hC8, 8'hCD}
    |=> ##1 o_hrdata == 32'h0000_00FF) else $error("direction read not all ones");
  a_five_fixed: assert property (up_q == 3'h4 && lo
    |-> o_port_five_dir == 4'hF) else $error("port five direction not fixed");
  a_cs_sel: assert property (up_q == 3'h4
    |-> o_port_eight_cs_sel == (~o_port_eight_oe_n & {5{lo}})) else $error("chip select wrong");
  c_read: cover property (acc && !i_hwrite);
  c_write: cover property (acc && i_hwrite);
  c_cs: cover property (o_port_eight_cs_sel != 5'h00);
endmodule : iopdd_monitor

// *** iopdd_ext_pins.sv ***
// partner: external circuitry driving the port seven pin levels
module iopdd_ext_pins (
  input  wire logic [7:0] i_level,
  output logic      [7:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // levels move a few ns after the edge, unrelated to the sampling instant
  assign #3 o_pins = i_level;
endmodule : iopdd_ext_pins

// *** io_port_data_direction_regs_tb.sv ***
// testbench: resets, read-back, direction and pin behaviour of the port block
module io_port_data_direction_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_sys_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [2:0]  i_mode = 3'h1;
  logic        i_hsel = 1'b0;
  logic        i_hwrite = 1'b0;
  logic [1:0]  i_htrans = 2'h0;
  logic [31:0] i_haddr = 32'h0000_0000;
  logic [31:0] i_hwdata = 32'h0000_0000;
  logic [31:0] o_hrdata;
  logic        o_hreadyout;
  logic        o_hresp;
  logic        rsp;
  logic [7:0]  lvl = 8'h00;
  logic [7:0]  i_port_seven_pins, o_port_three_out, o_port_four_out, q;
  logic [3:0]  o_port_five_dir;
  logic [4:0]  o_port_eight_out, o_port_eight_oe_n, o_port_eight_cs_sel;
  int          n_fail = 0;
  int          total_checks = 0;
  always #4 i_sys_clk = ~i_sys_clk;
  iopdd_top u_dut (.i_sys_clk, .i_rst, .i_mode, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'h2), .i_hwdata,
    .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .o_port_three_out, .o_port_four_out,
    .i_port_seven_pins, .o_port_five_dir, .o_port_eight_out, .o_port_eight_oe_n, .o_port_eight_cs_sel);
  iopdd_ext_pins u_pins (.i_level(lvl), .o_pins(i_port_seven_pins));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one single transfer: address phase, then data phase until ready; byte address is four times the index
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {22'h00_0000, a, 2'b00};
    i_hwrite <= w;
    do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= {24'h00_0000, d};
    do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
    q = o_hrdata[7:0];
    rsp = o_hresp;
  endtask : xfer
  task rdc(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(q, exp);
    chk({7'h00, rsp}, 8'h00);
  endtask : rdc
  task do_reset(input logic [2:0] m);
    i_rst <= 1'b1;
    i_mode <= m;
    repeat (12) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
  endtask : do_reset
  // modes 1 to 7: reset values, then direction writes and their pin effect
  task t_modes;
    for (int m = 1; m < 8; m++) begin
      do_reset(m[2:0]);
      rdc(8'hC6, 8'h00);
      rdc(8'hC7, 8'h00);
      rdc(8'hCF, 8'hE0);
      rdc(8'hCD, 8'hFF);
      chk({3'h0, o_port_eight_oe_n}, m < 5 ? 8'h0F : 8'h1F);
      chk({3'h0, o_port_eight_cs_sel}, m < 5 ? 8'h10 : 8'h00);
      chk({4'h0, o_port_five_dir}, m < 5 ? 8'h0F : 8'h00);
      xfer(1'b1, 8'hC8, 8'hFA);
      xfer(1'b1, 8'hCD, 8'hF5);
      xfer(1'b1, 8'hCF, 8'h15);
      rdc(8'hC8, 8'hFF);
      rdc(8'hCF, 8'hF5);
      chk({4'h0, o_port_five_dir}, m < 5 ? 8'h0F : 8'h0A);
      chk({3'h0, o_port_eight_oe_n}, 8'h0A);
      chk({3'h0, o_port_eight_cs_sel}, m < 5 ? 8'h15 : 8'h00);
      chk({3'h0, o_port_eight_out}, 8'h15);
    end
    $display("test modes done");
  endtask : t_modes
  task t_data;
    xfer(1'b1, 8'hC6, 8'hA5);
    xfer(1'b1, 8'hC7, 8'h5A);
    rdc(8'hC6, 8'hA5);
    rdc(8'hC7, 8'h5A);
    chk(o_port_three_out, 8'hA5);
    chk(o_port_four_out, 8'h5A);
    $display("test data done");
  endtask : t_data
  // pin levels read back, writes to them and to a hole ignored
  task t_pins;
    lvl <= 8'h3C;
    repeat (4) @(posedge i_sys_clk);
    xfer(1'b1, 8'hCE, 8'hC3);
    rdc(8'hCE, 8'h3C);
    lvl <= 8'hC3;
    repeat (4) @(posedge i_sys_clk);
    rdc(8'hCE, 8'hC3);
    xfer(1'b1, 8'hC0, 8'h77);
    rdc(8'hC0, 8'h00);
    $display("test pins done");
  endtask : t_pins
  task stop_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    t_modes;
    t_data;
    t_pins;
    stop_test;
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #60000;
    n_fail++;
    stop_test;
  end
endmodule : io_port_data_direction_regs_tb
bind iopdd_top iopdd_monitor u_mon (.i_sys_clk, .i_rst, .i_mode, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata,
  .o_hrdata, .o_hreadyout, .o_port_three_out, .o_port_five_dir, .o_port_eight_oe_n, .o_port_eight_cs_sel);
